//--- mls_pkg.sv
`default_nettype none
package mls_pkg;
	// Frame layout: start bit, op bit, then eight data bits MSB first
	localparam int LINK_BITS = 8;
	localparam logic [2:0] LAST_BIT_INDEX = 3'(LINK_BITS - 1);
	localparam logic LINE_IDLE = 1'b1;
	localparam logic START_LEVEL = 1'b0;
	localparam logic OP_READ = 1'b1;
	localparam logic OP_WRITE = 1'b0;

	// Elastic store for received words
	localparam int FIFO_DEPTH = 16;

	// Link clock from the master divider, never faster than 8 Mb/s
	localparam int MCLK_PERIOD_NS = 10;
	localparam int LINK_MIN_PERIOD_NS = 125;
	localparam int LINK_HALF_CYCLES =
		(LINK_MIN_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);

	// Module power-on settle time and quiet period before first contact
	localparam int CLOCK_SETTLE_NS = 10000;
	localparam int POR_CYCLES = (CLOCK_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int STARTUP_DELAY_S = 1;
	localparam int STARTUP_CYCLES = STARTUP_DELAY_S * (1000000000 / MCLK_PERIOD_NS);

	typedef enum logic [2:0] {
		SL_IDLE,
		SL_OP,
		SL_RECV,
		SL_ACK_WR,
		SL_ACK_RD,
		SL_SEND
	} mls_slave_state_type;

	typedef enum logic [2:0] {
		MS_IDLE,
		MS_OP,
		MS_WBITS,
		MS_ACK,
		MS_RBITS
	} mls_master_state_type;
endpackage
`default_nettype wire

//--- mls_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Four-wire management link, one master and one slave
interface mls_link_if;
	logic link_clk;
	logic master_to_slave_data;
	logic slave_to_master_data;
	logic attention_wait_line;

	modport master (
		output link_clk,
		output master_to_slave_data,
		input slave_to_master_data,
		input attention_wait_line
	);

	modport slave (
		input link_clk,
		input master_to_slave_data,
		output slave_to_master_data,
		output attention_wait_line
	);
endinterface
`default_nettype wire

//--- mls_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module mls_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	// Pointers wrap naturally, so depth must be a power of two
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign in_ready = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	// Storage needs no reset; count guards every read
	always_ff @(posedge mclk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- mls_slave_end.sv
`timescale 1ns/1ns
`default_nettype none
// Module end of the management link; link logic runs on the master's clock
module mls_slave_end
	import mls_pkg::*;
#(
	parameter int POR_LEN = POR_CYCLES,
	parameter int STARTUP_LEN = STARTUP_CYCLES,
	parameter int RX_DEPTH = FIFO_DEPTH
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cold_reset_input,
	mls_link_if.slave link,
	output logic [LINK_BITS-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [LINK_BITS-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic link_up,
	output logic startup_done
);
	generate
		if (POR_LEN < 1 || STARTUP_LEN < 1)
		begin : g_bad_len
			$error("reset and startup lengths must be at least one cycle");
		end
	endgenerate

	// ---- mclk domain ----
	logic ac_meta_reg;
	logic ac_sync_reg;
	logic local_rst;
	logic [31:0] por_cnt_reg;
	logic por_done_reg;
	logic [31:0] start_cnt_reg;
	logic startup_done_reg;
	logic rx_req_meta_reg;
	logic rx_req_sync_reg;
	logic rx_ack_reg;
	logic rx_pending;
	logic rx_fifo_ready;
	logic tx_req_reg;
	logic [LINK_BITS-1:0] tx_hold_reg;
	logic tx_ack_meta_reg;
	logic tx_ack_sync_reg;

	// ---- link domain ----
	logic run_meta_reg;
	logic run_sync_reg;
	logic talk_meta_reg;
	logic talk_sync_reg;
	logic rx_ack_meta_reg;
	logic rx_ack_sync_reg;
	logic tx_req_meta_reg;
	logic tx_req_sync_reg;
	mls_slave_state_type state_reg;
	logic [2:0] bit_cnt_reg;
	logic [LINK_BITS-1:0] shift_reg;
	logic sda_reg;
	logic attn_reg;
	logic rx_req_reg;
	logic [LINK_BITS-1:0] rx_hold_reg;
	logic tx_ack_reg;
	logic have_tx;
	logic rx_free;

	// Cold reset pin is asynchronous, so it is synchronised first
	always_ff @(posedge mclk)
	begin
		ac_meta_reg <= cold_reset_input;
		ac_sync_reg <= ac_meta_reg;
	end

	assign local_rst = srst || !ac_sync_reg;

	always_ff @(posedge mclk)
	begin
		if (local_rst)
		begin
			por_cnt_reg <= '0;
			por_done_reg <= 1'b0;
		end
		else if (!por_done_reg)
		begin
			por_cnt_reg <= por_cnt_reg + 32'h1;
			por_done_reg <= (por_cnt_reg == 32'(POR_LEN - 1));
		end
	end

	always_ff @(posedge mclk)
	begin
		if (local_rst || !por_done_reg)
		begin
			start_cnt_reg <= '0;
			startup_done_reg <= 1'b0;
		end
		else if (!startup_done_reg)
		begin
			start_cnt_reg <= start_cnt_reg + 32'h1;
			startup_done_reg <= (start_cnt_reg == 32'(STARTUP_LEN - 1));
		end
	end

	assign link_up = por_done_reg;
	assign startup_done = startup_done_reg;

	// Handshake flags coming back from the link domain
	always_ff @(posedge mclk)
	begin
		rx_req_meta_reg <= rx_req_reg;
		rx_req_sync_reg <= rx_req_meta_reg;
		tx_ack_meta_reg <= tx_ack_reg;
		tx_ack_sync_reg <= tx_ack_meta_reg;
	end

	// A received word waits in its holding register until the fifo takes it;
	// a full fifo therefore stalls the link through the wait line
	assign rx_pending = (rx_req_sync_reg != rx_ack_reg);

	always_ff @(posedge mclk)
	begin
		if (local_rst || !por_done_reg)
			rx_ack_reg <= 1'b0;
		else if (rx_pending && rx_fifo_ready)
			rx_ack_reg <= !rx_ack_reg;
	end

	mls_fifo #(
		.WIDTH(LINK_BITS),
		.DEPTH(RX_DEPTH)
	) u_rx_fifo (
		.mclk(mclk),
		.srst(local_rst),
		.in_data(rx_hold_reg),
		.in_valid(rx_pending),
		.in_ready(rx_fifo_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	// One outbound word at a time; tx_hold stays still until acknowledged
	assign tx_ready = por_done_reg && (tx_req_reg == tx_ack_sync_reg);

	always_ff @(posedge mclk)
	begin
		if (local_rst || !por_done_reg)
		begin
			tx_req_reg <= 1'b0;
			tx_hold_reg <= '0;
		end
		else if (tx_valid && tx_ready)
		begin
			tx_req_reg <= !tx_req_reg;
			tx_hold_reg <= tx_data;
		end
	end

	// Levels and handshake flags entering the link domain
	always_ff @(posedge link.link_clk)
	begin
		run_meta_reg <= por_done_reg;
		run_sync_reg <= run_meta_reg;
		talk_meta_reg <= startup_done_reg;
		talk_sync_reg <= talk_meta_reg;
		rx_ack_meta_reg <= rx_ack_reg;
		rx_ack_sync_reg <= rx_ack_meta_reg;
		tx_req_meta_reg <= tx_req_reg;
		tx_req_sync_reg <= tx_req_meta_reg;
	end

	assign have_tx = (tx_req_sync_reg != tx_ack_reg);
	assign rx_free = (rx_ack_sync_reg == rx_req_reg);

	assign link.slave_to_master_data = sda_reg;
	assign link.attention_wait_line = attn_reg;

	always_ff @(posedge link.link_clk)
	begin
		if (!run_sync_reg)
		begin
			state_reg <= SL_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			sda_reg <= LINE_IDLE;
			attn_reg <= 1'b0;
			rx_req_reg <= 1'b0;
			rx_hold_reg <= '0;
			tx_ack_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				SL_IDLE:
				begin
					if (link.master_to_slave_data == START_LEVEL)
					begin
						state_reg <= SL_OP;
						attn_reg <= 1'b0;
					end
					else
						attn_reg <= talk_sync_reg && have_tx;
				end
				SL_OP:
				begin
					bit_cnt_reg <= '0;
					if (link.master_to_slave_data == OP_READ)
					begin
						attn_reg <= 1'b1;
						state_reg <= SL_ACK_RD;
					end
					else
						state_reg <= SL_RECV;
				end
				SL_RECV:
				begin
					shift_reg <= {shift_reg[LINK_BITS-2:0], link.master_to_slave_data};
					if (bit_cnt_reg == LAST_BIT_INDEX)
					begin
						attn_reg <= 1'b1;
						state_reg <= SL_ACK_WR;
					end
					else
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
				end
				SL_ACK_WR:
				begin
					if (rx_free)
					begin
						rx_hold_reg <= shift_reg;
						rx_req_reg <= !rx_req_reg;
						attn_reg <= 1'b0;
						state_reg <= SL_IDLE;
					end
				end
				SL_ACK_RD:
				begin
					if (have_tx)
					begin
						sda_reg <= tx_hold_reg[LINK_BITS-1];
						shift_reg <= tx_hold_reg;
						tx_ack_reg <= !tx_ack_reg;
						attn_reg <= 1'b0;
						bit_cnt_reg <= '0;
						state_reg <= SL_SEND;
					end
				end
				SL_SEND:
				begin
					if (bit_cnt_reg == LAST_BIT_INDEX)
					begin
						sda_reg <= LINE_IDLE;
						state_reg <= SL_IDLE;
					end
					else
					begin
						sda_reg <= shift_reg[LINK_BITS-2];
						shift_reg <= {shift_reg[LINK_BITS-2:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
				end
				default:
					state_reg <= SL_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- mls_master_end.sv
`timescale 1ns/1ns
`default_nettype none
// Controller end of the management link; makes the link clock by division
module mls_master_end
	import mls_pkg::*;
#(
	parameter int HALF_CYCLES = LINK_HALF_CYCLES
)
(
	input wire logic mclk,
	input wire logic srst,
	mls_link_if.master link,
	input wire logic [LINK_BITS-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [LINK_BITS-1:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	localparam int HW = $clog2(HALF_CYCLES + 1);
	localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYCLES - 1);

	// Inputs need two sync stages plus one cycle before the sampling edge
	// link rate limit
	generate
		if (HALF_CYCLES < 3 || 2 * HALF_CYCLES * MCLK_PERIOD_NS < LINK_MIN_PERIOD_NS)
		begin : g_bad_half
			$error("link half period too short for the input sync or the rate limit");
		end
	endgenerate

	logic [HW-1:0] half_cnt_reg;
	logic clk_reg;
	logic fall;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic attn_meta_reg;
	logic attn_sync_reg;
	mls_master_state_type state_reg;
	logic [2:0] bit_cnt_reg;
	logic [LINK_BITS-1:0] shift_reg;
	logic rd_op_reg;
	logic line_out_reg;
	logic [LINK_BITS-1:0] rd_data_reg;
	logic rd_valid_reg;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			half_cnt_reg <= '0;
			clk_reg <= 1'b0;
		end
		else if (half_cnt_reg == HALF_LAST)
		begin
			half_cnt_reg <= '0;
			clk_reg <= !clk_reg;
		end
		else
			half_cnt_reg <= half_cnt_reg + 1'b1;
	end

	// All master actions happen where the link clock falls
	assign fall = clk_reg && (half_cnt_reg == HALF_LAST);
	assign link.link_clk = clk_reg;
	assign link.master_to_slave_data = line_out_reg;

	// Slave lines change on the rising edge; resynchronise before use
	always_ff @(posedge mclk)
	begin
		sda_meta_reg <= link.slave_to_master_data;
		sda_sync_reg <= sda_meta_reg;
		attn_meta_reg <= link.attention_wait_line;
		attn_sync_reg <= attn_meta_reg;
	end

	// Attention takes priority over a pending write
	assign wr_ready = (state_reg == MS_IDLE) && fall && !attn_sync_reg;
	assign busy = (state_reg != MS_IDLE);
	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;

	// Frame sequencer
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_reg <= MS_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			rd_op_reg <= 1'b0;
			line_out_reg <= LINE_IDLE;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_valid_reg <= 1'b0;
			if (fall)
			begin
				unique case (state_reg)
					MS_IDLE:
					begin
						if (attn_sync_reg)
						begin
							line_out_reg <= START_LEVEL;
							rd_op_reg <= OP_READ;
							state_reg <= MS_OP;
						end
						else if (wr_valid)
						begin
							line_out_reg <= START_LEVEL;
							rd_op_reg <= OP_WRITE;
							shift_reg <= wr_data;
							state_reg <= MS_OP;
						end
					end
					MS_OP:
					begin
						line_out_reg <= rd_op_reg;
						bit_cnt_reg <= '0;
						state_reg <= (rd_op_reg == OP_READ) ? MS_ACK : MS_WBITS;
					end
					MS_WBITS:
					begin
						line_out_reg <= shift_reg[LINK_BITS-1];
						shift_reg <= {shift_reg[LINK_BITS-2:0], 1'b0};
						if (bit_cnt_reg == LAST_BIT_INDEX)
							state_reg <= MS_ACK;
						else
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
					MS_ACK:
					begin
						line_out_reg <= LINE_IDLE;
						if (!attn_sync_reg)
						begin
							if (rd_op_reg == OP_READ)
							begin
								shift_reg <= {shift_reg[LINK_BITS-2:0], sda_sync_reg};
								bit_cnt_reg <= 3'h1;
								state_reg <= MS_RBITS;
							end
							else
								state_reg <= MS_IDLE;
						end
					end
					MS_RBITS:
					begin
						shift_reg <= {shift_reg[LINK_BITS-2:0], sda_sync_reg};
						if (bit_cnt_reg == LAST_BIT_INDEX)
						begin
							rd_data_reg <= {shift_reg[LINK_BITS-2:0], sda_sync_reg};
							rd_valid_reg <= 1'b1;
							state_reg <= MS_IDLE;
						end
						else
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
					default:
						state_reg <= MS_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- mls_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the four link wires from the system clock side
module mls_link_checker
#(
	parameter int HALF_CYCLES = 7,
	parameter int POR_LEN = 20,
	parameter int STARTUP_LEN = 200
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cold_reset_input,
	input wire logic link_clk,
	input wire logic master_to_slave_data,
	input wire logic slave_to_master_data,
	input wire logic attention_wait_line
);
	localparam int LINK_PERIOD = 2 * HALF_CYCLES;
	logic [7:0] half_cnt_reg;
	logic edge_seen_reg;
	logic [31:0] up_cnt_reg;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst || !cold_reset_input);

	// Cycles since the last link clock edge
	always_ff @(posedge mclk)
	begin
		if (srst || $changed(link_clk))
			half_cnt_reg <= 8'h00;
		else
			half_cnt_reg <= half_cnt_reg + 8'h01;
	end

	// The first edge after reset has no reference point, so it is not timed
	always_ff @(posedge mclk)
	begin
		if (srst)
			edge_seen_reg <= 1'b0;
		else if ($changed(link_clk))
			edge_seen_reg <= 1'b1;
	end

	// Time since either reset let go; saturates so it never wraps
	always_ff @(posedge mclk)
	begin
		if (srst || !cold_reset_input)
			up_cnt_reg <= 32'h0;
		else if (up_cnt_reg != 32'hffffffff)
			up_cnt_reg <= up_cnt_reg + 32'h1;
	end

	// Start bit followed one link period later by a read op bit
	sequence read_start;
		!master_to_slave_data ##LINK_PERIOD master_to_slave_data;
	endsequence

	chk_link_half_period: assert property (
		edge_seen_reg && $changed(link_clk) |-> half_cnt_reg == 8'(HALF_CYCLES - 1))
		else $error("link clock half period wrong");
	chk_data_on_fall: assert property (
		$changed(master_to_slave_data) |-> $fell(link_clk))
		else $error("master data moved off a falling link edge");
	chk_sda_on_rise: assert property (
		$changed(slave_to_master_data) |-> $rose(link_clk))
		else $error("slave data moved off a rising link edge");
	chk_wait_on_rise: assert property (
		$changed(attention_wait_line) |-> $rose(link_clk))
		else $error("wait line moved off a rising link edge");
	chk_quiet_after_reset: assert property (
		$rose(attention_wait_line) |-> up_cnt_reg >= 32'(POR_LEN + STARTUP_LEN))
		else $error("attention raised before the quiet time");
	chk_attention_read: assert property (
		$fell(master_to_slave_data) && attention_wait_line |-> read_start)
		else $error("attention did not lead to a read");
	chk_wait_stretch: assert property (
		$fell(link_clk) && attention_wait_line && $past(attention_wait_line, LINK_PERIOD)
		|-> master_to_slave_data)
		else $error("master moved on while wait was held");
	chk_reset_idle: assert property (
		$fell(srst) |-> !link_clk && master_to_slave_data)
		else $error("link not idle after reset");
endmodule
`default_nettype wire

//--- test_mgmt_link_slave_port.sv
`timescale 1ns/1ns
`default_nettype none
// Both link ends face each other; the bench works their user sides
module test_mgmt_link_slave_port
	import mls_pkg::*;
;
	localparam int POR_LEN = 20;
	localparam int STARTUP_LEN = 200;
	logic mclk, srst, cold_reset_input, wr_valid, wr_ready, rd_valid, busy;
	logic rx_valid, rx_ready, tx_valid, tx_ready, link_up, startup_done;
	logic [7:0] wr_data, rd_data, rx_data, tx_data;
	logic [7:0] rd_pat [3] = '{8'h81, 8'h7e, 8'hff};
	int fails, checks_done;

	mls_link_if link_bus ();
	mls_master_end u_mls_master_end (.mclk(mclk), .srst(srst), .link(link_bus),
		.wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
	mls_slave_end #(.POR_LEN(POR_LEN), .STARTUP_LEN(STARTUP_LEN)) u_mls_slave_end (
		.mclk(mclk), .srst(srst), .cold_reset_input(cold_reset_input), .link(link_bus),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .link_up(link_up),
		.startup_done(startup_done));
	mls_link_checker #(.HALF_CYCLES(LINK_HALF_CYCLES), .POR_LEN(POR_LEN),
		.STARTUP_LEN(STARTUP_LEN)) u_mls_link_checker (.mclk(mclk), .srst(srst),
		.cold_reset_input(cold_reset_input), .link_clk(link_bus.link_clk),
		.master_to_slave_data(link_bus.master_to_slave_data),
		.slave_to_master_data(link_bus.slave_to_master_data),
		.attention_wait_line(link_bus.attention_wait_line));

	// System clock, 100 MHz
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic flag(input int k);
		case (k)
			0: return wr_ready;
			1: return tx_ready;
			2: return rx_valid;
			default: return rd_valid;
		endcase
	endfunction

	// Steps to just after the next rising edge, where outputs have settled
	task automatic next_cycle();
		@(posedge mclk);
		#1;
	endtask

	// Bounded wait for a flag, looked at after the edge so no race with its launch
	task automatic wait_for(input int k, input string what);
		int n;
		n = 0;
		while (flag(k) !== 1'b1 && n < 3000)
		begin
			next_cycle();
			n++;
		end
		check(what, 8'h01, {7'h00, flag(k)});
	endtask

	// Request stands through the taking edge; one edge passes before the next call
	task automatic master_write(input logic [7:0] b);
		wr_data = b;
		wr_valid = 1'b1;
		wait_for(0, "wr_ready");
		next_cycle();
		wr_valid = 1'b0;
		next_cycle();
	endtask

	task automatic slave_send(input logic [7:0] b);
		tx_data = b;
		tx_valid = 1'b1;
		wait_for(1, "tx_ready");
		next_cycle();
		tx_valid = 1'b0;
		next_cycle();
	endtask

	task automatic expect_rx(input logic [7:0] exp);
		wait_for(2, "rx_valid");
		check("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		next_cycle();
		rx_ready = 1'b0;
		next_cycle();
	endtask

	// The read pulse stands one cycle, so data is taken in that cycle
	task automatic wait_rd(input logic [7:0] exp);
		wait_for(3, "rd_valid");
		check("rd_data", exp, rd_data);
	endtask

	task automatic tally_and_finish();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		fails = 0;
		checks_done = 0;
		srst = 1'b1;
		cold_reset_input = 1'b1;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		rx_ready = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		repeat (6) @(posedge mclk);
		#1 srst = 1'b0;
		repeat (POR_LEN - 1) @(posedge mclk);
		#1 check("link_up", 8'h00, {7'h00, link_up}); // still held
		check("tx_ready", 8'h00, {7'h00, tx_ready}); // still held
		repeat (4) @(posedge mclk);
		#1 check("link_up", 8'h01, {7'h00, link_up}); // released
		slave_send(8'h5a); // word waiting early
		// Margin on both sides of the end of the quiet time
		repeat (STARTUP_LEN - 50) @(posedge mclk);
		#1 check("startup_done", 8'h00, {7'h00, startup_done}); // still quiet
		check("wait_line", 8'h00, {7'h00, link_bus.attention_wait_line}); // no early call
		wait_rd(8'h5a); // first read
		check("startup_done", 8'h01, {7'h00, startup_done}); // read after quiet
		$display("test startup done");
		// fill until the slave stretches, then drain
		for (int i = 0; i < 18; i++)
			master_write(8'(i * 8'h25 + 8'h05)); // writes
		repeat (400) @(posedge mclk);
		#1 check("busy", 8'h01, {7'h00, busy}); // stretched
		check("wait_line", 8'h01, {7'h00, link_bus.attention_wait_line}); // held
		for (int i = 0; i < 18; i++)
			expect_rx(8'(i * 8'h25 + 8'h05)); // order kept
		repeat (30) @(posedge mclk);
		#1 check("busy", 8'h00, {7'h00, busy}); // released
		$display("test fill and drain done");
		for (int i = 0; i < 3; i++)
		begin
			slave_send(rd_pat[i]); // request
			wait_rd(rd_pat[i]); // data back
		end
		$display("test reads done");
		cold_reset_input = 1'b0;
		repeat (60) @(posedge mclk);
		#1 check("link_up", 8'h00, {7'h00, link_up}); // held
		check("startup_done", 8'h00, {7'h00, startup_done}); // cleared
		cold_reset_input = 1'b1;
		repeat (POR_LEN) @(posedge mclk);
		#1 check("link_up", 8'h00, {7'h00, link_up}); // hold again
		repeat (6) @(posedge mclk);
		#1 check("link_up", 8'h01, {7'h00, link_up}); // out again
		// A frame now would raise the wait line inside the quiet time
		repeat (STARTUP_LEN) @(posedge mclk);
		#1 check("startup_done", 8'h01, {7'h00, startup_done}); // quiet over again
		master_write(8'h96); // after restart
		expect_rx(8'h96); // link usable
		$display("test cold reset done");
		tally_and_finish();
	end

	// About four times the expected run length
	initial
	begin
		#200000;
		fails++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
`default_nettype wire
